/* hdl/fspi_pkg.sv */
// Constants shared by the parallel flash command controller.
// Assumes a 100 MHz system clock; all counts derive from it.
package fspi_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_NS = 10;
   localparam int T_WP_NS = 40;
   localparam int T_RC_NS = 70;
   localparam int T_SETTLE_NS = 1000;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;

   ////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_ADDR = 12'h004;
   localparam logic [11:0] REG_WDATA = 12'h008;
   localparam logic [11:0] REG_RDATA = 12'h00C;
   localparam logic [11:0] REG_STATUS = 12'h010;
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_START_BIT = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_MODE_LSB = 2;
   localparam int STAT_DQ7_BIT = 4;
   localparam int STAT_REFUSED_BIT = 5;
   localparam logic [15:0] WORD_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // Operation codes written to the control register
   localparam logic [3:0] OP_READ = 4'h0;
   localparam logic [3:0] OP_PROG = 4'h1;
   localparam logic [3:0] OP_SEC = 4'h2;
   localparam logic [3:0] OP_BLK = 4'h3;
   localparam logic [3:0] OP_CHIP = 4'h4;
   localparam logic [3:0] OP_ID = 4'h5;
   localparam logic [3:0] OP_CFI = 4'h6;
   localparam logic [3:0] OP_EXIT1 = 4'h7;
   localparam logic [3:0] OP_EXIT3 = 4'h8;

   // Device mode as tracked by the controller
   localparam logic [1:0] MODE_READ = 2'h0;
   localparam logic [1:0] MODE_ID = 2'h1;
   localparam logic [1:0] MODE_QUERY = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Flash command words
   localparam logic [14:0] UNLK_A1 = 15'h5555;
   localparam logic [14:0] UNLK_A2 = 15'h2AAA;
   localparam logic [7:0] CODE_AA = 8'hAA;
   localparam logic [7:0] CODE_55 = 8'h55;
   localparam logic [7:0] CODE_PROG = 8'hA0;
   localparam logic [7:0] CODE_ERASE = 8'h80;
   localparam logic [7:0] CODE_SEC = 8'h30;
   localparam logic [7:0] CODE_BLK = 8'h50;
   localparam logic [7:0] CODE_CHIP = 8'h10;
   localparam logic [7:0] CODE_ID = 8'h90;
   localparam logic [7:0] CODE_CFI = 8'h98;
   localparam logic [7:0] CODE_EXIT = 8'hF0;
   localparam int SEC_LSB = 11;
   localparam int BLK_LSB = 15;

endpackage : fspi_pkg

/* hdl/fspi_pin_cycle.sv */
// One asynchronous flash bus cycle (write or read) on the flash pins.
// Assumes fl_dq_in is synchronous to mclk; strobes last whole cycles.
`timescale 1ns/1ps
module fspi_pin_cycle import fspi_pkg::*; #(
   parameter int AW = 19,
   parameter int WP_CYC_P = WP_CYC,
   parameter int RC_CYC_P = RC_CYC
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Cycle request
   input wire logic go,
   input wire logic wr,
   input wire logic [AW-1:0] addr,
   input wire logic [15:0] wdata,
   output logic done,
   output logic [15:0] rdata,
   // Flash pins
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic [AW-1:0] fl_addr,
   output logic [15:0] fl_dq_out,
   output logic fl_dq_oe,
   input wire logic [15:0] fl_dq_in
);

   typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STRB, P_HOLD} fspi_pin_e;

   fspi_pin_e state_ff;
   logic [7:0] cnt_ff;
   logic wr_ff;

   ////////////////////////////////////////////////////////////////////////
   // Strobe sequencing: whole-cycle pulses, far above the glitch filter
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_ff <= P_IDLE;
         cnt_ff <= 8'h00;
         wr_ff <= 1'b0;
         done <= 1'b0;
         rdata <= WORD_RST;
         fl_ce_n <= 1'b1;
         fl_oe_n <= 1'b1;
         fl_we_n <= 1'b1;
         fl_addr <= '0;
         fl_dq_out <= WORD_RST;
         fl_dq_oe <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         case (state_ff)
            P_IDLE: begin
               if (go) begin
                  fl_ce_n <= 1'b0;
                  fl_addr <= addr;
                  fl_dq_out <= wdata;
                  fl_dq_oe <= wr;
                  wr_ff <= wr;
                  state_ff <= P_SETUP;
               end
            end
            P_SETUP: begin
               // Write strobe only with output gate high
               if (wr_ff) begin
                  fl_we_n <= 1'b0;
               end else begin
                  fl_oe_n <= 1'b0;
               end
               cnt_ff <= 8'h00;
               state_ff <= P_STRB;
            end
            P_STRB: begin
               cnt_ff <= cnt_ff + 8'h01;
               if ((wr_ff && cnt_ff == 8'(WP_CYC_P - 1)) ||
                   (!wr_ff && cnt_ff == 8'(RC_CYC_P - 1))) begin
                  fl_we_n <= 1'b1;
                  fl_oe_n <= 1'b1;
                  if (!wr_ff) begin
                     rdata <= fl_dq_in;
                  end
                  state_ff <= P_HOLD;
               end
            end
            P_HOLD: begin
               fl_ce_n <= 1'b1;
               fl_dq_oe <= 1'b0;
               done <= 1'b1;
               state_ff <= P_IDLE;
            end
            default: state_ff <= P_IDLE;
         endcase
      end
   end

endmodule : fspi_pin_cycle

/* hdl/fspi_host.sv */
// Host controller for a 16-bit parallel NOR flash: APB registers in,
// unlock/command sequences, toggle polling and mode tracking out.
// Assumes APB and the flash data inputs are synchronous to mclk.
`timescale 1ns/1ps
module fspi_host import fspi_pkg::*; #(
   parameter int AW = 19,
   parameter int WP_CYC_P = WP_CYC,
   parameter int RC_CYC_P = RC_CYC,
   parameter int SETTLE_CYC_P = SETTLE_CYC
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash pins
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic [AW-1:0] fl_addr,
   output logic [15:0] fl_dq_out,
   output logic fl_dq_oe,
   input wire logic [15:0] fl_dq_in
);

   typedef enum logic [2:0] {
      S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLL_WAIT, S_SETTLE
   } fspi_state_e;

   fspi_state_e state_ff;
   logic [3:0] op_ff;
   logic [2:0] step_ff;
   logic [AW-1:0] tgt_addr_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic go_ff;
   logic bus_wr_ff;
   logic [AW-1:0] bus_addr_ff;
   logic [15:0] bus_data_ff;
   logic poll_first_ff;
   logic tog_ff;
   logic [7:0] settle_ff;
   logic done_ff;
   logic refused_ff;
   logic dq7_ff;
   logic [1:0] mode_ff;
   logic cyc_done;
   logic [15:0] bus_rdata;
   logic apb_wr;
   logic ctrl_start;
   logic cmd_go;
   logic last_step;
   logic needs_poll;
   logic fin_w;
   logic [31:0] rd_word;

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic addr_mapped(input logic [11:0] a);
      if (a == REG_CTRL) addr_mapped = 1'b1;
      else if (a == REG_ADDR) addr_mapped = 1'b1;
      else if (a == REG_WDATA) addr_mapped = 1'b1;
      else if (a == REG_RDATA) addr_mapped = 1'b1;
      else if (a == REG_STATUS) addr_mapped = 1'b1;
      else addr_mapped = 1'b0;
   endfunction : addr_mapped

   function automatic logic op_valid(input logic [3:0] op);
      op_valid = (op <= OP_EXIT3);
   endfunction : op_valid

   function automatic logic [2:0] seq_len(input logic [3:0] op);
      case (op)
         OP_PROG: seq_len = 3'd4;
         OP_SEC, OP_BLK, OP_CHIP: seq_len = 3'd6;
         OP_ID, OP_CFI, OP_EXIT3: seq_len = 3'd3;
         default: seq_len = 3'd1;
      endcase
   endfunction : seq_len

   // Address and data word of one sequence cycle
   function automatic logic [AW+15:0] seq_word(input logic [3:0] op,
         input logic [2:0] st, input logic [AW-1:0] ta,
         input logic [15:0] wd);
      logic [AW-1:0] a;
      logic [7:0] c;
      a = AW'(UNLK_A1);
      c = CODE_AA;
      case (st)
         3'd0: begin
            if (op == OP_READ) a = ta;
            if (op == OP_EXIT1) c = CODE_EXIT;
         end
         3'd1: begin
            a = AW'(UNLK_A2);
            c = CODE_55;
         end
         3'd2: begin
            case (op)
               OP_PROG: c = CODE_PROG;
               OP_ID: c = CODE_ID;
               OP_CFI: c = CODE_CFI;
               OP_EXIT3: c = CODE_EXIT;
               default: c = CODE_ERASE;
            endcase
         end
         3'd4: begin
            a = AW'(UNLK_A2);
            c = CODE_55;
         end
         3'd5: begin
            case (op)
               OP_SEC: begin
                  a = {ta[AW-1:SEC_LSB], SEC_LSB'(0)};
                  c = CODE_SEC;
               end
               OP_BLK: begin
                  a = {ta[AW-1:BLK_LSB], BLK_LSB'(0)};
                  c = CODE_BLK;
               end
               default: c = CODE_CHIP;
            endcase
         end
         default: ;
      endcase
      // Upper byte held low in command cycles
      if (op == OP_PROG && st == 3'd3) seq_word = {ta, wd};
      else seq_word = {a, 8'h00, c};
   endfunction : seq_word

   ////////////////////////////////////////////////////////////////////////
   // APB slave: no wait states, answer taken in the access phase
   assign apb_wr = psel & penable & pready & pwrite & addr_mapped(paddr);
   assign ctrl_start = apb_wr && paddr == REG_CTRL && pwdata[CTRL_START_BIT];
   // Commands while busy are refused, never sent to the flash
   assign cmd_go = ctrl_start && state_ff == S_IDLE &&
                   op_valid(pwdata[CTRL_OP_LSB +: 4]);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (paddr == REG_CTRL) begin
         rd_word[CTRL_OP_LSB +: 4] = op_ff;
      end else if (paddr == REG_ADDR) begin
         rd_word[AW-1:0] = tgt_addr_ff;
      end else if (paddr == REG_WDATA) begin
         rd_word[15:0] = wdata_ff;
      end else if (paddr == REG_RDATA) begin
         rd_word[15:0] = rdata_ff;
      end else if (paddr == REG_STATUS) begin
         rd_word[STAT_BUSY_BIT] = (state_ff != S_IDLE);
         rd_word[STAT_DONE_BIT] = done_ff;
         rd_word[STAT_MODE_LSB +: 2] = mode_ff;
         rd_word[STAT_DQ7_BIT] = dq7_ff;
         rd_word[STAT_REFUSED_BIT] = refused_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         pready <= psel & ~penable & ~pready;
         pslverr <= psel & ~penable & ~addr_mapped(paddr);
         prdata <= rd_word;
      end
   end

   // Software-written target, data and operation
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tgt_addr_ff <= '0;
         wdata_ff <= WORD_RST;
         op_ff <= OP_READ;
      end else if (clk_en && apb_wr) begin
         if (paddr == REG_ADDR) begin
            tgt_addr_ff <= pwdata[AW-1:0];
         end else if (paddr == REG_WDATA) begin
            wdata_ff <= pwdata[15:0];
         end else if (cmd_go) begin
            op_ff <= pwdata[CTRL_OP_LSB +: 4];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   assign last_step = (step_ff == seq_len(op_ff) - 3'd1);
   assign needs_poll = (op_ff == OP_PROG || op_ff == OP_SEC ||
                        op_ff == OP_BLK || op_ff == OP_CHIP);
   assign fin_w = clk_en && ((state_ff == S_WAIT && cyc_done && last_step &&
                  !needs_poll) || (state_ff == S_SETTLE &&
                  settle_ff == 8'(SETTLE_CYC_P - 1)));

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_ff <= S_IDLE;
         step_ff <= 3'd0;
         go_ff <= 1'b0;
         bus_wr_ff <= 1'b0;
         bus_addr_ff <= '0;
         bus_data_ff <= WORD_RST;
         poll_first_ff <= 1'b0;
         tog_ff <= 1'b0;
         settle_ff <= 8'h00;
         rdata_ff <= WORD_RST;
      end else if (clk_en) begin
         go_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               if (cmd_go) begin
                  step_ff <= 3'd0;
                  state_ff <= S_ISSUE;
               end
            end
            S_ISSUE: begin
               go_ff <= 1'b1;
               bus_wr_ff <= (op_ff != OP_READ);
               {bus_addr_ff, bus_data_ff} <=
                  seq_word(op_ff, step_ff, tgt_addr_ff, wdata_ff);
               state_ff <= S_WAIT;
            end
            S_WAIT: begin
               if (cyc_done) begin
                  if (op_ff == OP_READ) begin
                     rdata_ff <= bus_rdata;
                  end
                  if (!last_step) begin
                     step_ff <= step_ff + 3'd1;
                     state_ff <= S_ISSUE;
                  end else if (needs_poll) begin
                     poll_first_ff <= 1'b1;
                     state_ff <= S_POLL;
                  end else begin
                     state_ff <= S_IDLE;
                  end
               end
            end
            S_POLL: begin
               go_ff <= 1'b1;
               bus_wr_ff <= 1'b0;
               bus_addr_ff <= tgt_addr_ff;
               state_ff <= S_POLL_WAIT;
            end
            S_POLL_WAIT: begin
               if (cyc_done) begin
                  tog_ff <= bus_rdata[6];
                  poll_first_ff <= 1'b0;
                  rdata_ff <= bus_rdata;
                  if (!poll_first_ff && bus_rdata[6] == tog_ff) begin
                     settle_ff <= 8'h00;
                     state_ff <= S_SETTLE;
                  end else begin
                     state_ff <= S_POLL;
                  end
               end
            end
            S_SETTLE: begin
               settle_ff <= settle_ff + 8'h01;
               if (settle_ff == 8'(SETTLE_CYC_P - 1)) begin
                  state_ff <= S_IDLE;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status: done and refused are sticky, write one clears, set wins
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         done_ff <= 1'b0;
         refused_ff <= 1'b0;
         dq7_ff <= 1'b0;
         mode_ff <= MODE_READ;
      end else if (clk_en) begin
         if (fin_w) begin
            done_ff <= 1'b1;
         end else if (apb_wr && paddr == REG_STATUS &&
                      pwdata[STAT_DONE_BIT]) begin
            done_ff <= 1'b0;
         end
         if (ctrl_start && !cmd_go) begin
            refused_ff <= 1'b1;
         end else if (apb_wr && paddr == REG_STATUS &&
                      pwdata[STAT_REFUSED_BIT]) begin
            refused_ff <= 1'b0;
         end
         if (fin_w && needs_poll) begin
            dq7_ff <= rdata_ff[7];
         end
         if (fin_w) begin
            case (op_ff)
               OP_ID: mode_ff <= MODE_ID;
               OP_CFI: mode_ff <= MODE_QUERY;
               OP_EXIT1, OP_EXIT3: mode_ff <= MODE_READ;
               default: ;
            endcase
         end
      end
   end

   fspi_pin_cycle #(
      .AW(AW),
      .WP_CYC_P(WP_CYC_P),
      .RC_CYC_P(RC_CYC_P)
   ) u_pins (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .go(go_ff),
      .wr(bus_wr_ff),
      .addr(bus_addr_ff),
      .wdata(bus_data_ff),
      .done(cyc_done),
      .rdata(bus_rdata),
      .fl_ce_n(fl_ce_n),
      .fl_oe_n(fl_oe_n),
      .fl_we_n(fl_we_n),
      .fl_addr(fl_addr),
      .fl_dq_out(fl_dq_out),
      .fl_dq_oe(fl_dq_oe),
      .fl_dq_in(fl_dq_in)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_poll_end;
      clk_en && state_ff == S_POLL_WAIT && cyc_done && !poll_first_ff &&
      bus_rdata[6] == tog_ff;
   endsequence

   sequence s_settle_hold;
      (state_ff == S_SETTLE && done_ff == $past(done_ff))[*8];
   endsequence

   a_settle_wait: assert property (s_poll_end |=> s_settle_hold)
      else $error("completion reported before settling interval");

   a_unlock_first: assert property (go_ff && step_ff == 3'd0 &&
      op_ff != OP_READ && op_ff != OP_EXIT1 |->
      bus_addr_ff == AW'(UNLK_A1) && bus_data_ff[7:0] == CODE_AA)
      else $error("first unlock cycle wrong");

   a_unlock_second: assert property (go_ff && step_ff == 3'd1 |->
      bus_addr_ff == AW'(UNLK_A2) && bus_data_ff[7:0] == CODE_55)
      else $error("second unlock cycle wrong");

   a_program_code: assert property (go_ff && op_ff == OP_PROG &&
      step_ff == 3'd2 |-> bus_data_ff[7:0] == CODE_PROG ##1 !go_ff)
      else $error("program command code wrong");

   a_erase_six: assert property (state_ff == S_POLL &&
      $past(state_ff) == S_WAIT && op_ff != OP_PROG |-> step_ff == 3'd5)
      else $error("erase polled before sixth cycle");

   a_erase_code: assert property (go_ff && bus_wr_ff &&
      step_ff == 3'd5 |->
      (op_ff == OP_SEC && bus_data_ff[7:0] == CODE_SEC) ||
      (op_ff == OP_BLK && bus_data_ff[7:0] == CODE_BLK) ||
      (op_ff == OP_CHIP && bus_data_ff[7:0] == CODE_CHIP &&
       bus_addr_ff == AW'(UNLK_A1)))
      else $error("erase final cycle wrong");

   a_query_entry: assert property (go_ff && op_ff == OP_CFI &&
      step_ff == 3'd2 |-> bus_addr_ff == AW'(UNLK_A1) &&
      bus_data_ff[7:0] == CODE_CFI)
      else $error("query entry cycle wrong");

   a_exit_code: assert property (go_ff && (op_ff == OP_EXIT1 ||
      (op_ff == OP_EXIT3 && step_ff == 3'd2)) |->
      bus_data_ff[7:0] == CODE_EXIT)
      else $error("exit command code wrong");

   a_mode_query: assert property (fin_w && op_ff == OP_CFI |=>
      mode_ff == MODE_QUERY && done_ff ##1 mode_ff == MODE_QUERY)
      else $error("query mode not recorded");

   a_upper_byte: assert property (go_ff && bus_wr_ff &&
      !(op_ff == OP_PROG && step_ff == 3'd3) |-> bus_data_ff[15:8] == 8'h00)
      else $error("upper byte driven in command cycle");

endmodule : fspi_host

/* bench/fspi_flash_model.sv */
// Behavioural 16-bit parallel flash seen from its pins.
// Assumes one host on the strobes; busy ends after a few polls.
`timescale 1ns/1ps
module fspi_flash_model #(
   parameter int AW = 19,
   parameter logic [15:0] MAKER = 16'h0A5C, // Arbitrary value
   parameter logic [15:0] PART = 16'h1E37, // Arbitrary value
   parameter int BUSY_READS = 3
) (
   // Flash strobes and address
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [AW-1:0] addr,
   // Data bus
   input wire logic [15:0] host_d,
   input wire logic host_oe,
   output logic [15:0] dq
);
   logic [2:0] st = 3'h0;
   logic [1:0] mode = 2'h0;
   int busy_end = 0;
   int polls = 0;
   logic ers = 1'b0;
   logic supply_ok = 1'b1;
   realtime t_fall = 0.0;
   logic [AW-1:0] ers_a = '0;
   logic [15:0] mem = 16'hFFFF;
   logic [15:0] rd;
   logic [15:0] lastv = 16'h0000;
   wire [14:0] a = addr[14:0];
   wire [7:0] d = host_d[7:0];
   wire ul = a == 15'h5555;
   wire busy = busy_end > polls;

   ////////////////////////////////////////////////////////////////////////
   // Unlock and command sequencing; always on, no bypass
   always @(negedge we_n) t_fall = $realtime;

   always @(posedge we_n) begin
      if (!ce_n && oe_n && !busy && supply_ok &&
          $realtime - t_fall >= 5.0) begin
         if (st == 3'h3) begin
            mem = host_d;
            ers = 1'b0;
            busy_end = polls + BUSY_READS;
            st = 3'h0;
         end else if (st == 3'h6) begin
            if ((ul && d == 8'h10) || d == 8'h30 || d == 8'h50) begin
               mem = 16'hFFFF;
               ers = 1'b1;
               ers_a = addr;
               busy_end = polls + BUSY_READS;
            end
            st = 3'h0;
         end else if (st == 3'h0 && d == 8'hF0) begin
            mode = 2'h0;
         end else if (st == 3'h0 || st == 3'h4) begin
            st = (ul && d == 8'hAA) ? st + 3'h1 : 3'h0;
         end else if (st == 3'h1 || st == 3'h5) begin
            st = (a == 15'h2AAA && d == 8'h55) ? st + 3'h1 : 3'h0;
         end else begin
            st = (ul && d == 8'hA0) ? 3'h3 : (ul && d == 8'h80) ? 3'h4 : 3'h0;
            if (ul && d == 8'h90) mode = 2'h1;
            if (ul && d == 8'h98) mode = 2'h2;
            if (ul && d == 8'hF0) mode = 2'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read side: status while busy, then mode-dependent data
   always @(posedge oe_n) begin
      if (!ce_n) begin
         lastv = rd;
         polls++;
      end
   end

   // Busy: inverted or zero bit 7, bit 6 toggles per read
   // Then id codes, query table or array data
   always_comb begin
      if (busy) rd = {8'h15, ers ? 1'b0 : ~mem[7], polls[0], 6'h2A};
      else if (mode == 2'h1) rd = addr[0] ? PART : MAKER;
      else if (mode == 2'h2) rd = (a == 15'h0010) ? 16'h0051 : 16'h0000;
      else rd = mem;
   end

   assign dq = host_oe ? host_d : (!ce_n && !oe_n) ? rd : ~lastv;
endmodule : fspi_flash_model

/* bench/fspi_host_tb.sv */
// Self-checking bench for the flash command controller.
// Assumes the behavioural flash model on the pins.
`timescale 1ns/1ps
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin failures++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, x); end end
module fspi_host_tb import fspi_pkg::*;;
   localparam logic [15:0] MK = 16'h0A5C; // Arbitrary value
   localparam logic [15:0] PT = 16'h1E37; // Arbitrary value
   logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, ce_n, oe_n, we_n, dq_oe, d7;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic [18:0] fa, ad;
   logic [15:0] dq_o, dq_i, wd;
   logic [64:0] q[$];
   logic [64:0] e;
   int failures = 0, n_tests = 0, cyc = 0;

   fspi_host #(.SETTLE_CYC_P(9)) dut (.mclk(mclk), .sys_rst(sys_rst),
      .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n),
      .fl_addr(fa), .fl_dq_out(dq_o), .fl_dq_oe(dq_oe), .fl_dq_in(dq_i));
   fspi_flash_model #(.MAKER(MK), .PART(PT)) flash (.ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .addr(fa), .host_d(dq_o),
      .host_oe(dq_oe), .dq(dq_i));

   initial begin
      forever #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB master; entered right after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
      q.push_back({a > 12'h010, m, x});
      apb(1'b0, a, 32'h0);
   endtask : rd

   function automatic logic [31:0] st(logic r, logic [1:0] m, logic dn);
      return {26'h0, r, d7, m, dn, 1'b0};
   endfunction : st

   // Poll until idle, check status, then clear the sticky bits
   task idle(input logic [31:0] s);
      rdv = 32'h1;
      while (rdv[0]) rd(12'h010, 32'h0, 32'h0);
      rd(12'h010, s, 32'hFFFFFFFF);
      apb(1'b1, 12'h010, 32'h22);
   endtask : idle

   task op(input logic [3:0] o, input logic [18:0] a, input logic [31:0] s);
      apb(1'b1, 12'h004, {13'h0, a});
      apb(1'b1, 12'h008, {16'h0, wd});
      apb(1'b1, 12'h000, {23'h0, 1'b1, 4'h0, o});
      idle(s);
   endtask : op

   task finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         finish_test();
      end
      if (psel && penable && pready && !pwrite) begin
         e = q.pop_front();
         `CHK(prdata & e[63:32], e[31:0])
         `CHK(pslverr, e[64])
      end
   end

   initial begin
      void'($urandom(14));
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      d7 = 1'b0;
      rd(12'h010, 32'h0, 32'hFFFFFFFF);
      rd(12'h020, 32'h0, 32'hFFFFFFFF);
      $display("test reset and unmapped done");
      wd = 16'($urandom);
      ad = 19'($urandom);
      d7 = wd[7];
      op(OP_PROG, ad, st(0, 0, 1));
      op(OP_READ, ad, st(0, 0, 1));
      rd(12'h00C, {16'h0, wd}, 32'hFFFF);
      $display("test program done");
      d7 = 1'b1;
      for (int o = 2; o < 5; o++) begin
         ad = 19'($urandom);
         op(4'(o), ad, st(0, 0, 1));
         if (o == 4) ad = 19'h05555;
         else ad &= (o == 2) ? 19'h7F800 : 19'h78000;
         `CHK(flash.ers_a, ad)
      end
      $display("test erase done");
      op(OP_ID, 19'h0, st(0, 1, 1));
      for (int i = 0; i < 2; i++) begin
         op(OP_READ, 19'(i), st(0, 1, 1));
         rd(12'h00C, {16'h0, i ? PT : MK}, 32'hFFFF);
      end
      op(OP_EXIT1, 19'h0, st(0, 0, 1));
      op(OP_CFI, 19'h0, st(0, 2, 1));
      op(OP_READ, 19'h10, st(0, 2, 1));
      rd(12'h00C, 32'h51, 32'hFFFF);
      op(OP_EXIT3, 19'h0, st(0, 0, 1));
      $display("test modes done");
      d7 = wd[7];
      apb(1'b1, 12'h000, 32'h101);
      apb(1'b1, 12'h000, 32'h107);
      idle(st(1, 0, 1));
      apb(1'b1, 12'h000, 32'h109);
      idle(st(1, 0, 0));
      $display("test refusal done");
      finish_test();
   end
endmodule : fspi_host_tb
